// File: inc/pin_mux_pkg.sv
// Constants and types shared by the port pin function multiplexer
package pin_mux_pkg;

  // Port widths
  localparam int PORT0_WIDTH = 8;
  localparam int PORT2_WIDTH = 4;

  // Pin positions on port 0
  localparam int P0_IRQ7_BIT = 0;
  localparam int P0_SDA_BIT = 3;
  localparam int P0_SCK_BIT = 4;
  localparam int P0_SIN_BIT = 5;
  localparam int P0_CS_BIT = 6;
  localparam int P0_TMRH_BIT = 7;

  // Pin positions on port 2
  localparam int P2_TMRB1_BIT = 0;
  localparam int P2_TMRB0_BIT = 1;
  localparam int P2_IRQ0_BIT = 2;
  localparam int P2_IRQ5_BIT = 3;

  // Timer B mode field encodings
  localparam logic [1:0] TMODE_TIMER = 2'h0;
  localparam logic [1:0] TMODE_PULSE = 2'h1;
  localparam logic [1:0] TMODE_ONESHOT = 2'h2;
  localparam logic [1:0] TMODE_WAIT_ONESHOT = 2'h3;

  // Timer C pin select value that routes its trigger to port 0 bit 0
  localparam logic [1:0] TRC_TRIG_SEL = 2'h2;

  // Both A/D trigger mode bits set
  localparam logic [1:0] ADC_TRIG_MODE = 2'h3;

  // Reset values
  localparam logic [7:0] PORT0_RESET = 8'h00;
  localparam logic [3:0] PORT2_RESET = 4'h0;

  // Pin function summary per pin, one-hot
  typedef enum logic [4:0] {
    PF_INPUT = 5'h01,
    PF_OUTPUT = 5'h02,
    PF_SEGMENT = 5'h04,
    PF_PERIPH_IN = 5'h08,
    PF_PERIPH_OUT = 5'h10
  } pin_func_type;

endpackage : pin_mux_pkg

// File: src/pin_sync.sv
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Both stages reset to low so pins read low until sampled
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : pin_sync

// File: src/pin_cell.sv
// One generic port pin: segment, peripheral or general-purpose drive
`timescale 1ns/1ps
module pin_cell (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic direction_i,
  input wire logic segment_en_i,
  input wire logic segment_val_i,
  input wire logic latch_i,
  input wire logic pullup_bit_i,
  input wire logic periph_out_sel_i,
  input wire logic periph_out_val_i,
  input wire logic periph_in_sel_i,
  input wire logic open_drain_i,
  input wire logic pin_level_i,
  input wire logic readback_sel_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic pullup_o,
  output logic read_o,
  output pin_mux_pkg::pin_func_type func_o
);

  // Combinational selection
  wire use_seg = segment_en_i;
  wire use_pout = !segment_en_i && periph_out_sel_i;
  wire use_gpo = !segment_en_i && !periph_out_sel_i && !periph_in_sel_i && direction_i;
  wire out_val = use_seg ? segment_val_i : (use_pout ? periph_out_val_i : latch_i);
  // Open drain only pulls low; high is released
  wire drive = use_seg || use_gpo || (use_pout && !(open_drain_i && out_val));
  // Pull-up only in input mode, never while segment drives
  wire pull = pullup_bit_i && !direction_i && !segment_en_i && !drive;
  // Read returns latch for output-mode pins unless readback select set
  wire rd = (direction_i && !readback_sel_i) ? latch_i : pin_level_i;
  pin_mux_pkg::pin_func_type func_nxt;

  // Function classification for status
  always_comb
  begin
    if (use_seg)
      func_nxt = pin_mux_pkg::PF_SEGMENT;
    else if (use_pout)
      func_nxt = pin_mux_pkg::PF_PERIPH_OUT;
    else if (periph_in_sel_i)
      func_nxt = pin_mux_pkg::PF_PERIPH_IN;
    else if (direction_i)
      func_nxt = pin_mux_pkg::PF_OUTPUT;
    else
      func_nxt = pin_mux_pkg::PF_INPUT;
  end

  // Registered pin outputs; data leaves from flip-flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pullup_o <= 1'b0;
      read_o <= 1'b0;
      func_o <= pin_mux_pkg::PF_INPUT;
    end
    else
    begin
      pin_o <= out_val;
      pin_oe_o <= drive;
      pullup_o <= pull;
      read_o <= rd;
      func_o <= func_nxt;
    end
  end

endmodule : pin_cell

// File: src/port_pin_function_select.sv
// Pin function multiplexer for port 0 bits 0-7 and port 2 bits 0-3
// What this block does
// [R1] Segment enable forces LCD segment drive output
// [R2] Otherwise direction bit picks input or output
// [R3] Pull-up bit enables pull-up on inputs
// [R4] Port0 bit0 becomes external interrupt 7 input
// [R5] Interrupt 7 setup plus trigger mode: A/D trigger
// [R6] Port0 bit3 carries I2C data when selected
// [R7] Port0 bit4 carries I2C clock when selected
// [R8] Serial data out open-drain in standard mode
// [R9] Software clears bit4 direction for open-drain clock
// [R10] Chip-select output open-drain when bit set
// [R11] Timer B mode 01 gives pulse output
// [R12] Modes 10, 11 give one-shot, wait one-shot
// [R13] Timer H output enable drives port0 bit7
// [R14] Port2 bits 2,3 become interrupts 0,5
// [R15] Pull-up applies only in input mode
// [R16] Readback select returns pin level always
`timescale 1ns/1ps
module port_pin_function_select (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Software control bits
  input wire logic [7:0] port0_direction_i,
  input wire logic [3:0] port2_direction_i,
  input wire logic [7:0] segment_enable_group0_i,
  input wire logic [3:0] segment_enable_group1_i,
  input wire logic [7:0] port0_pullup_control_i,
  input wire logic [3:0] port2_pullup_control_i,
  input wire logic [7:0] port0_latch_i,
  input wire logic [3:0] port2_latch_i,
  input wire logic input_readback_select_i,
  input wire logic irq7_pin_select_i,
  input wire logic irq7_enable_bit_i,
  input wire logic irq0_enable_bit_i,
  input wire logic irq5_enable_bit_i,
  input wire logic [1:0] adc_trigger_mode_i,
  input wire logic [1:0] timer_c_pin_select_i,
  input wire logic timer_c_pwm2_i,
  input wire logic timer_c_trigger_enable_i,
  input wire logic serial_data_pin_select_i,
  input wire logic serial_clock_pin_select_i,
  input wire logic serial_in_pin_select_i,
  input wire logic serial_cs_pin_select_i,
  input wire logic i2c_select_bit_i,
  input wire logic i2c_enable_bit_i,
  input wire logic serial_clock_source_bit_i,
  input wire logic serial_out_open_drain_bit_i,
  input wire logic bidirectional_mode_bit_i,
  input wire logic chip_select_open_drain_bit_i,
  input wire logic [1:0] chip_select_mode_i,
  input wire logic timer_h_output_enable_i,
  input wire logic [1:0] timer_b1_mode_field_i,
  input wire logic [1:0] timer_b0_mode_field_i,
  input wire logic timer_b1_output_control_i,
  input wire logic timer_b0_output_control_i,
  // Peripheral side signals, same clock
  input wire logic [7:0] lcd_segment_p0_i,
  input wire logic [3:0] lcd_segment_p2_i,
  input wire logic serial_data_out_i,
  input wire logic serial_data_oe_i,
  input wire logic serial_clock_out_i,
  input wire logic serial_clock_oe_i,
  input wire logic serial_cs_out_i,
  input wire logic i2c_data_out_i,
  input wire logic i2c_clock_out_i,
  input wire logic timer_h_wave_out_i,
  input wire logic timer_b1_wave_out_i,
  input wire logic timer_b0_wave_out_i,
  // Board pins, four signals each
  input wire logic [7:0] port0_pin_i,
  output logic [7:0] port0_pin_o,
  output logic [7:0] port0_pin_oe_o,
  output logic [7:0] port0_pullup_o,
  input wire logic [3:0] port2_pin_i,
  output logic [3:0] port2_pin_o,
  output logic [3:0] port2_pin_oe_o,
  output logic [3:0] port2_pullup_o,
  // Values read back by software and peripheral inputs
  output logic [7:0] port0_read_o,
  output logic [3:0] port2_read_o,
  output logic ext_irq7_input_o,
  output logic adc_ext_trigger_o,
  output logic timer_c_trigger_in_o,
  output logic ext_irq0_input_o,
  output logic ext_irq5_input_o,
  output logic serial_data_in_o,
  output logic serial_clock_in_o,
  output logic serial_chip_select_in_o,
  output logic i2c_data_in_o,
  output logic i2c_clock_in_o,
  output logic [39:0] port0_function_o,
  output logic [19:0] port2_function_o
);

  // Synchronised pin levels; pins are outside the clock domain
  logic [7:0] p0_sync;
  logic [3:0] p2_sync;

  pin_sync #(
    .WIDTH(pin_mux_pkg::PORT0_WIDTH)
  ) u_sync_p0 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i(port0_pin_i),
    .sync_o(p0_sync)
  );

  pin_sync #(
    .WIDTH(pin_mux_pkg::PORT2_WIDTH)
  ) u_sync_p2 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i(port2_pin_i),
    .sync_o(p2_sync)
  );

  // Common qualifiers: pin in input mode, not a segment
  wire [7:0] p0_in_ok = ~port0_direction_i & ~segment_enable_group0_i;
  wire [3:0] p2_in_ok = ~port2_direction_i & ~segment_enable_group1_i;

  // [R4] interrupt 7 routing
  wire irq7_sel = p0_in_ok[pin_mux_pkg::P0_IRQ7_BIT] && !irq7_pin_select_i
    && irq7_enable_bit_i && (timer_c_pin_select_i != pin_mux_pkg::TRC_TRIG_SEL);

  // [R5] A/D trigger on the same pin
  wire adc_ext_trigger_sel = irq7_sel && (adc_trigger_mode_i == pin_mux_pkg::ADC_TRIG_MODE);

  // Shares bit 0
  // Timer C trigger outside PWM2 mode
  wire trc_sel = p0_in_ok[pin_mux_pkg::P0_IRQ7_BIT]
    && (timer_c_pin_select_i == pin_mux_pkg::TRC_TRIG_SEL) && !timer_c_pwm2_i
    && timer_c_trigger_enable_i;

  // [R6] I2C data on bit 3
  wire sda_sel = p0_in_ok[pin_mux_pkg::P0_SDA_BIT] && serial_data_pin_select_i
    && i2c_select_bit_i && i2c_enable_bit_i;
  // I2C off: serial data
  wire sso_sel = p0_in_ok[pin_mux_pkg::P0_SDA_BIT] && serial_data_pin_select_i
    && !i2c_select_bit_i;
  // [R7] I2C clock on bit 4, internal clock source only
  wire scl_sel = !port0_direction_i[pin_mux_pkg::P0_SCK_BIT]
    && !segment_enable_group0_i[pin_mux_pkg::P0_SCK_BIT] && serial_clock_pin_select_i
    && i2c_select_bit_i && i2c_enable_bit_i && !serial_clock_source_bit_i;

  // [R9] clock pin relies on software keeping direction 0
  wire serial_clock_pin_sel = p0_in_ok[pin_mux_pkg::P0_SCK_BIT] && serial_clock_pin_select_i
    && !i2c_select_bit_i && serial_clock_source_bit_i;

  // Ignores direction
  wire ssi_sel = !segment_enable_group0_i[pin_mux_pkg::P0_SIN_BIT]
    && serial_in_pin_select_i && !i2c_select_bit_i;

  // Mode 00: plain port
  wire scs_sel = p0_in_ok[pin_mux_pkg::P0_CS_BIT] && serial_cs_pin_select_i
    && !i2c_select_bit_i && (|chip_select_mode_i);
  // Mode bit 1: output
  wire scs_drive = scs_sel && chip_select_mode_i[1];

  // [R13] timer H output ignores direction
  wire timer_h_wave_out_sel = timer_h_output_enable_i
    && !segment_enable_group0_i[pin_mux_pkg::P0_TMRH_BIT];

  // [R8] data out open drain only in standard mode
  wire sso_od = serial_out_open_drain_bit_i && !bidirectional_mode_bit_i;

  // [R10] chip-select open drain
  wire scs_od = chip_select_open_drain_bit_i;

  // [R11] [R12] timer B waveform when mode nonzero and output control 0
  wire trb1_sel = (timer_b1_mode_field_i != pin_mux_pkg::TMODE_TIMER)
    && !timer_b1_output_control_i;
  // Timer B0 alike
  wire trb0_sel = (timer_b0_mode_field_i != pin_mux_pkg::TMODE_TIMER)
    && !timer_b0_output_control_i;

  // Output control 1 forces port output in every timer B mode
  wire trb1_force = timer_b1_output_control_i;
  // Same for B0
  wire trb0_force = timer_b0_output_control_i;

  // [R14] interrupt 0 and 5 inputs
  wire irq0_sel = p2_in_ok[pin_mux_pkg::P2_IRQ0_BIT] && irq0_enable_bit_i;
  // Interrupt 5, bit 3
  wire irq5_sel = p2_in_ok[pin_mux_pkg::P2_IRQ5_BIT] && irq5_enable_bit_i;

  // Per-pin peripheral selections for port 0
  wire [7:0] p0_pout_sel = {timer_h_wave_out_sel, scs_drive, 1'b0,
    serial_clock_pin_sel && serial_clock_oe_i || scl_sel,
    sso_sel && serial_data_oe_i || sda_sel, 3'h0};
  // Output values
  wire [7:0] p0_pout_val = {timer_h_wave_out_i, serial_cs_out_i, 1'b0,
    scl_sel ? i2c_clock_out_i : serial_clock_out_i,
    sda_sel ? i2c_data_out_i : serial_data_out_i, 3'h0};
  // Input routing
  wire [7:0] p0_pin_sel = {1'b0, scs_sel && !scs_drive, ssi_sel,
    serial_clock_pin_sel && !serial_clock_oe_i, sso_sel && !serial_data_oe_i, 2'h0,
    irq7_sel || trc_sel};

  // I2C lines always open drain; serial clock open drain follows data-out bit
  wire [7:0] p0_od = {1'b0, scs_od, 1'b0, scl_sel || serial_out_open_drain_bit_i,
    sda_sel || sso_od, 3'h0};

  // Port 2 selections
  wire [3:0] p2_pout_sel = {2'h0, trb0_sel, trb1_sel};
  // Timer B waves
  wire [3:0] p2_pout_val = {2'h0, timer_b0_wave_out_i, timer_b1_wave_out_i};
  wire [3:0] p2_pin_sel = {irq5_sel, irq0_sel, 2'h0};

  // Output control forces output mode on timer B pins
  wire [3:0] p2_dir = port2_direction_i | {2'h0, trb0_force, trb1_force};

  // One cell per port 0 pin
  genvar gi;
  generate
    for (gi = 0; gi < pin_mux_pkg::PORT0_WIDTH; gi++)
    begin : g_port0
      // [R1] [R2] [R3] [R15] [R16] generic pin behaviour
      pin_cell u_cell (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .direction_i(port0_direction_i[gi]),
        .segment_en_i(segment_enable_group0_i[gi]),
        .segment_val_i(lcd_segment_p0_i[gi]),
        .latch_i(port0_latch_i[gi]),
        .pullup_bit_i(port0_pullup_control_i[gi]),
        .periph_out_sel_i(p0_pout_sel[gi]),
        .periph_out_val_i(p0_pout_val[gi]),
        .periph_in_sel_i(p0_pin_sel[gi]),
        .open_drain_i(p0_od[gi]),
        .pin_level_i(p0_sync[gi]),
        .readback_sel_i(input_readback_select_i),
        .pin_o(port0_pin_o[gi]),
        .pin_oe_o(port0_pin_oe_o[gi]),
        .pullup_o(port0_pullup_o[gi]),
        .read_o(port0_read_o[gi]),
        .func_o(port0_function_o[gi*5 +: 5])
      );
    end

    for (gi = 0; gi < pin_mux_pkg::PORT2_WIDTH; gi++)
    begin : g_port2
      // Same pin behaviour for port 2
      pin_cell u_cell (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .direction_i(p2_dir[gi]),
        .segment_en_i(segment_enable_group1_i[gi]),
        .segment_val_i(lcd_segment_p2_i[gi]),
        .latch_i(port2_latch_i[gi]),
        .pullup_bit_i(port2_pullup_control_i[gi]),
        .periph_out_sel_i(p2_pout_sel[gi]),
        .periph_out_val_i(p2_pout_val[gi]),
        .periph_in_sel_i(p2_pin_sel[gi]),
        .open_drain_i(1'b0),
        .pin_level_i(p2_sync[gi]),
        .readback_sel_i(input_readback_select_i),
        .pin_o(port2_pin_o[gi]),
        .pin_oe_o(port2_pin_oe_o[gi]),
        .pullup_o(port2_pullup_o[gi]),
        .read_o(port2_read_o[gi]),
        .func_o(port2_function_o[gi*5 +: 5])
      );
    end
  endgenerate

  // Peripheral inputs registered; unselected inputs idle high
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // Inactive high
      ext_irq7_input_o <= 1'b1;
      adc_ext_trigger_o <= 1'b1;
      timer_c_trigger_in_o <= 1'b1;
      ext_irq0_input_o <= 1'b1;
      ext_irq5_input_o <= 1'b1;
      serial_data_in_o <= 1'b1;
      serial_clock_in_o <= 1'b1;
      serial_chip_select_in_o <= 1'b1;
      i2c_data_in_o <= 1'b1;
      i2c_clock_in_o <= 1'b1;
    end
    else
    begin
      // Idle high so a deselected pin never fakes an active-low event
      ext_irq7_input_o <= irq7_sel ? p0_sync[0] : 1'b1;
      adc_ext_trigger_o <= adc_ext_trigger_sel ? p0_sync[0] : 1'b1;
      timer_c_trigger_in_o <= trc_sel ? p0_sync[0] : 1'b1;
      ext_irq0_input_o <= irq0_sel ? p2_sync[2] : 1'b1;
      ext_irq5_input_o <= irq5_sel ? p2_sync[3] : 1'b1;
      serial_data_in_o <= (sso_sel || ssi_sel) ? (ssi_sel ? p0_sync[5] : p0_sync[3]) : 1'b1;
      serial_clock_in_o <= serial_clock_pin_sel ? p0_sync[4] : 1'b1;
      serial_chip_select_in_o <= scs_sel ? p0_sync[6] : 1'b1;
      i2c_data_in_o <= sda_sel ? p0_sync[3] : 1'b1;
      i2c_clock_in_o <= scl_sel ? p0_sync[4] : 1'b1;
    end
  end

endmodule : port_pin_function_select

// File: testbench/pin_mux_checker.sv
// Assertions on the port pin multiplexer ports
`timescale 1ns/1ps
module pin_mux_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] port0_direction_i,
  input wire logic [3:0] port2_direction_i,
  input wire logic [7:0] segment_enable_group0_i,
  input wire logic [3:0] segment_enable_group1_i,
  input wire logic [7:0] port0_pullup_control_i,
  input wire logic [7:0] port0_latch_i,
  input wire logic input_readback_select_i,
  input wire logic irq0_enable_bit_i,
  input wire logic timer_h_output_enable_i,
  input wire logic [1:0] timer_b1_mode_field_i,
  input wire logic timer_b1_output_control_i,
  input wire logic [7:0] lcd_segment_p0_i,
  input wire logic timer_h_wave_out_i,
  input wire logic timer_b1_wave_out_i,
  input wire logic [7:0] port0_pin_i,
  input wire logic [3:0] port2_pin_i,
  input wire logic [7:0] port0_pin_o,
  input wire logic [7:0] port0_pin_oe_o,
  input wire logic [7:0] port0_pullup_o,
  input wire logic [7:0] port0_read_o,
  input wire logic [3:0] port2_pin_o,
  input wire logic [3:0] port2_pin_oe_o,
  input wire logic ext_irq0_input_o
);
  // Single clock domain, async reset
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_SEG_DRIVE: assert property (
    segment_enable_group0_i[1] |=>
    port0_pin_oe_o[1] && port0_pin_o[1] == $past(lcd_segment_p0_i[1]))
    else $error("segment drive wrong");
  AST_GPIO_OUT: assert property (
    !segment_enable_group0_i[1] && port0_direction_i[1] |=>
    port0_pin_oe_o[1] && port0_pin_o[1] == $past(port0_latch_i[1]))
    else $error("output mode wrong");
  AST_GPIO_IN: assert property (
    !segment_enable_group0_i[1] && !port0_direction_i[1] |=> !port0_pin_oe_o[1])
    else $error("input mode drives");
  AST_PULLUP: assert property (
    !segment_enable_group0_i[6] && !port0_direction_i[6] && port0_pullup_control_i[6]
    |=> port0_pullup_o[6])
    else $error("pull-up missing");
  AST_TMRH: assert property (
    timer_h_output_enable_i && !segment_enable_group0_i[7] |=>
    port0_pin_oe_o[7] && port0_pin_o[7] == $past(timer_h_wave_out_i))
    else $error("timer H output wrong");
  AST_TMRB: assert property (
    !segment_enable_group1_i[0] && !timer_b1_output_control_i &&
    timer_b1_mode_field_i != pin_mux_pkg::TMODE_TIMER |=>
    port2_pin_oe_o[0] && port2_pin_o[0] == $past(timer_b1_wave_out_i))
    else $error("timer B output wrong");
  AST_IRQ0: assert property (
    (!port2_direction_i[2] && !segment_enable_group1_i[2] && irq0_enable_bit_i) [*4]
    |-> ext_irq0_input_o == $past(port2_pin_i[2], 3))
    else $error("interrupt 0 input wrong");
  AST_READ: assert property (
    input_readback_select_i [*4] |-> port0_read_o == $past(port0_pin_i, 3))
    else $error("readback wrong");
  COV_SEG: cover property (segment_enable_group0_i[1] ##1 port0_pin_oe_o[1]);
  COV_TMRB: cover property (timer_b1_mode_field_i == 2'h3 ##1 port2_pin_oe_o[0]);
  COV_READ: cover property (input_readback_select_i [*4]);
endmodule : pin_mux_checker

// File: testbench/board_pin_model.sv
// Board side of the port pins: drivers, pull-ups, floating lines
`timescale 1ns/1ps
module board_pin_model #(
  parameter int W = 8
) (
  input wire logic clk_sys_i,
  input wire logic [W-1:0] pin_o_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pullup_i,
  input wire logic [W-1:0] ext_en_i,
  input wire logic [W-1:0] ext_val_i,
  output logic [W-1:0] level_o
);
  // Undriven lines flip each cycle so no stale level reads as valid
  logic [W-1:0] float_r = '0;
  always_ff @(posedge clk_sys_i)
  begin
    float_r <= ~float_r;
  end
  // Device first, then board driver, then pull-up
  assign level_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_val_i) |
                   (~oe_i & ~ext_en_i & (pullup_i | float_r));
endmodule : board_pin_model

// File: testbench/port_pin_function_select_tb.sv
// Self-checking bench for the port pin multiplexer
`timescale 1ns/1ps
module port_pin_function_select_tb;
  logic clk_sys_i = '0, rst_b_i = '0;
  logic [7:0] port0_direction_i = '0, segment_enable_group0_i = '0, port0_pullup_control_i = '0;
  logic [7:0] port0_latch_i = '0, lcd_segment_p0_i = '0;
  logic [3:0] port2_direction_i = '0, segment_enable_group1_i = '0, port2_pullup_control_i = '0;
  logic [3:0] port2_latch_i = '0, lcd_segment_p2_i = '0;
  logic input_readback_select_i = '0, irq7_pin_select_i = '0, irq7_enable_bit_i = '0;
  logic irq0_enable_bit_i = '0, irq5_enable_bit_i = '0, timer_c_pwm2_i = '0;
  logic timer_c_trigger_enable_i = '0, serial_data_pin_select_i = '0;
  logic serial_clock_pin_select_i = '0, serial_in_pin_select_i = '0, serial_cs_pin_select_i = '0;
  logic i2c_select_bit_i = '0, i2c_enable_bit_i = '0, serial_clock_source_bit_i = '0;
  logic serial_out_open_drain_bit_i = '0, bidirectional_mode_bit_i = '0;
  logic chip_select_open_drain_bit_i = '0, timer_h_output_enable_i = '0;
  logic timer_b1_output_control_i = '0, timer_b0_output_control_i = '0;
  logic [1:0] adc_trigger_mode_i = '0, timer_c_pin_select_i = '0, chip_select_mode_i = '0;
  logic [1:0] timer_b1_mode_field_i = '0, timer_b0_mode_field_i = '0;
  logic serial_data_out_i = '0, serial_data_oe_i = '0, serial_clock_out_i = '0;
  logic serial_clock_oe_i = '0, serial_cs_out_i = '0, i2c_data_out_i = '0, i2c_clock_out_i = '0;
  logic timer_h_wave_out_i = '0, timer_b1_wave_out_i = '0, timer_b0_wave_out_i = '0;
  logic [7:0] port0_pin_i, port0_pin_o, port0_pin_oe_o, port0_pullup_o, port0_read_o;
  logic [3:0] port2_pin_i, port2_pin_o, port2_pin_oe_o, port2_pullup_o, port2_read_o;
  logic ext_irq7_input_o, adc_ext_trigger_o, timer_c_trigger_in_o, ext_irq0_input_o;
  logic ext_irq5_input_o, serial_data_in_o, serial_clock_in_o, serial_chip_select_in_o;
  logic i2c_data_in_o, i2c_clock_in_o;
  logic [39:0] port0_function_o;
  logic [19:0] port2_function_o;
  // Board drivers standing on the pins
  logic [7:0] ext0_en = '0, ext0_val = '0;
  logic [3:0] ext2_en = '0, ext2_val = '0;
  int fails = 0, samples_checked = 0;
  port_pin_function_select dut_u (.*);
  board_pin_model #(.W(8)) board0_u (.clk_sys_i, .pin_o_i(port0_pin_o), .oe_i(port0_pin_oe_o),
    .pullup_i(port0_pullup_o), .ext_en_i(ext0_en), .ext_val_i(ext0_val), .level_o(port0_pin_i));
  board_pin_model #(.W(4)) board2_u (.clk_sys_i, .pin_o_i(port2_pin_o), .oe_i(port2_pin_oe_o),
    .pullup_i(port2_pullup_o), .ext_en_i(ext2_en), .ext_val_i(ext2_val), .level_o(port2_pin_i));
  // Compare one value, count it
  task automatic compare(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : compare
  // Let n edges pass, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // 10 MHz clock
  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard
  initial
  begin
    repeat (2000) @(posedge clk_sys_i);
    fails++;
    give_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    compare(port0_function_o, {8{5'h01}});
    compare({port2_read_o, port2_function_o}, {4'h0, {4{5'h01}}});
    compare({ext_irq7_input_o, i2c_data_in_o, serial_data_in_o, serial_clock_in_o,
      serial_chip_select_in_o}, 5'h1F);
    rst_b_i <= 1'h1;
    @(posedge clk_sys_i);
    port0_direction_i <= 8'hFF;
    port0_latch_i <= 8'hA5;
    settle(1);
    compare({port0_pin_oe_o, port0_pin_o}, 16'hFFA5);
    // Segment on low nibble, overriding cleared direction on bits 0 and 2
    @(posedge clk_sys_i);
    segment_enable_group0_i <= 8'h0F;
    lcd_segment_p0_i <= 8'h3C;
    port0_direction_i <= 8'hFA;
    settle(1);
    compare({port0_pin_oe_o, port0_pin_o}, 16'hFFAC);
    compare(port0_function_o[9:0], 10'h084);
    // Inputs on high nibble; bit 7 left to its pull-up
    @(posedge clk_sys_i);
    segment_enable_group0_i <= 8'h00;
    port0_direction_i <= 8'h0F;
    port0_pullup_control_i <= 8'hFF;
    port2_pullup_control_i <= 4'hF;
    port0_latch_i <= 8'h55;
    ext0_en <= 8'h70;
    ext0_val <= 8'h20;
    settle(4);
    compare({port0_pin_oe_o, port0_pullup_o}, 16'h0FF0);
    compare(port2_pullup_o, 4'hF);
    compare(port0_read_o, 8'hA5);
    @(posedge clk_sys_i);
    input_readback_select_i <= 1'h1;
    settle(4);
    compare(port0_read_o, 8'hA5);
    // Interrupt 7 and A/D trigger on port 0 bit 0
    @(posedge clk_sys_i);
    input_readback_select_i <= 1'h0;
    port0_direction_i <= 8'h00;
    irq7_enable_bit_i <= 1'h1;
    adc_trigger_mode_i <= pin_mux_pkg::ADC_TRIG_MODE;
    ext0_en <= 8'h01;
    ext0_val <= 8'h00;
    settle(4);
    compare({ext_irq7_input_o, adc_ext_trigger_o, timer_c_trigger_in_o}, 3'h1);
    @(posedge clk_sys_i);
    adc_trigger_mode_i <= 2'h1;
    settle(4);
    compare({ext_irq7_input_o, adc_ext_trigger_o}, 2'h1);
    @(posedge clk_sys_i);
    irq7_pin_select_i <= 1'h1;
    settle(4);
    compare(ext_irq7_input_o, 1'h1);
    @(posedge clk_sys_i);
    irq7_pin_select_i <= 1'h0;
    timer_c_pin_select_i <= pin_mux_pkg::TRC_TRIG_SEL;
    settle(4);
    compare(ext_irq7_input_o, 1'h1);
    // Interrupts 0 and 5 on port 2
    @(posedge clk_sys_i);
    irq0_enable_bit_i <= 1'h1;
    irq5_enable_bit_i <= 1'h1;
    ext2_en <= 4'hC;
    ext2_val <= 4'h4;
    settle(4);
    compare({ext_irq0_input_o, ext_irq5_input_o}, 2'h2);
    compare(port2_read_o, 4'h7);
    @(posedge clk_sys_i);
    port2_direction_i <= 4'h8;
    settle(4);
    compare({ext_irq0_input_o, ext_irq5_input_o}, 2'h3);
    // Every timer B waveform mode on both pins
    for (int m = 1; m < 4; m++)
    begin
      @(posedge clk_sys_i);
      timer_b1_mode_field_i <= m[1:0];
      timer_b0_mode_field_i <= m[1:0];
      timer_b1_wave_out_i <= m[0];
      timer_b0_wave_out_i <= ~m[0];
      settle(1);
      compare({port2_pin_oe_o[1:0], port2_pin_o[1:0]}, {2'h3, ~m[0], m[0]});
    end
    @(posedge clk_sys_i);
    timer_b1_output_control_i <= 1'h1;
    timer_b0_output_control_i <= 1'h1;
    port2_latch_i <= 4'h3;
    settle(1);
    compare({port2_pin_oe_o[1:0], port2_pin_o[1:0]}, 4'hF);
    // Timer H, then segment taking the pin back
    @(posedge clk_sys_i);
    timer_h_output_enable_i <= 1'h1;
    timer_h_wave_out_i <= 1'h1;
    settle(1);
    compare({port0_pin_oe_o[7], port0_pin_o[7]}, 2'h3);
    @(posedge clk_sys_i);
    segment_enable_group0_i <= 8'h80;
    lcd_segment_p0_i <= 8'h00;
    lcd_segment_p2_i <= 4'hF;
    settle(1);
    compare({port0_pin_oe_o[7], port0_pin_o[7]}, 2'h2);
    // I2C pair with outside pull on the clock line
    @(posedge clk_sys_i);
    segment_enable_group0_i <= 8'h00;
    timer_h_output_enable_i <= 1'h0;
    serial_data_pin_select_i <= 1'h1;
    serial_clock_pin_select_i <= 1'h1;
    i2c_select_bit_i <= 1'h1;
    i2c_enable_bit_i <= 1'h1;
    i2c_clock_out_i <= 1'h1;
    port0_pullup_control_i <= 8'h18;
    ext0_en <= 8'h10;
    ext0_val <= 8'h10;
    settle(4);
    // clock pin kept in input mode
    compare({port0_pin_oe_o[4:3], port0_pin_o[3], i2c_clock_in_o, i2c_data_in_o}, 5'h0A);
    @(posedge clk_sys_i);
    i2c_data_out_i <= 1'h1;
    ext0_en <= 8'h18;
    settle(4);
    compare({port0_pin_oe_o[4:3], i2c_data_in_o}, 3'h0);
    // Serial data out, open-drain then push-pull
    @(posedge clk_sys_i);
    i2c_select_bit_i <= 1'h0;
    serial_out_open_drain_bit_i <= 1'h1;
    serial_data_oe_i <= 1'h1;
    serial_data_out_i <= 1'h1;
    serial_clock_source_bit_i <= 1'h1;
    serial_clock_oe_i <= 1'h1;
    serial_clock_out_i <= 1'h0;
    ext0_en <= 8'h00;
    settle(1);
    compare(port0_pin_oe_o[3], 1'h0);
    @(posedge clk_sys_i);
    bidirectional_mode_bit_i <= 1'h1;
    settle(1);
    compare({port0_pin_oe_o[3], port0_pin_o[3]}, 2'h3);
    // Chip select open-drain
    @(posedge clk_sys_i);
    serial_cs_pin_select_i <= 1'h1;
    chip_select_mode_i <= 2'h2;
    chip_select_open_drain_bit_i <= 1'h1;
    serial_cs_out_i <= 1'h1;
    settle(1);
    compare(port0_pin_oe_o[6], 1'h0);
    @(posedge clk_sys_i);
    serial_cs_out_i <= 1'h0;
    settle(1);
    compare({port0_pin_oe_o[6], port0_pin_o[6]}, 2'h2);
    compare(serial_clock_in_o, 1'h0);
    give_verdict();
  end
endmodule : port_pin_function_select_tb
bind port_pin_function_select pin_mux_checker chk_u (.*);
